// [pkg/ebswc_pkg.sv]
package ebswc_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_WIDTH  = 8'h00;
  localparam logic [7:0] OFS_WAIT   = 8'h04;
  localparam logic [7:0] OFS_AWAIT  = 8'h08;
  localparam logic [7:0] OFS_PWAIT  = 8'h0C;
  localparam logic [7:0] OFS_MODE   = 8'h10;
  localparam logic [7:0] OFS_PIN    = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Reset values
  localparam logic [15:0] RST_WIDTH = 16'h5555;
  localparam logic [15:0] RST_WAIT  = 16'h7777;
  localparam logic [15:0] RST_AWAIT = 16'hFFFF;
  localparam logic [2:0]  RST_PWAIT = 3'h0;

  // Field layout: block n width bit 2n, wait field 4n+2..4n, hold 2n, setup 2n+1
  localparam int WIDTH_STRIDE = 2;
  localparam int WAIT_STRIDE  = 4;
  localparam int WAIT_W       = 3;
  localparam int AW_STRIDE    = 2;
  localparam int AW_HOLD_BIT  = 0;
  localparam int AW_SETUP_BIT = 1;

  // Memory block decode of the 16 MB external window
  localparam int REQ_ADDR_W = 24;
  localparam int BLK1_BIT   = 21;
  localparam int BLK2_BIT   = 22;
  localparam int BLK3_BIT   = 23;

  // Base bus clocks per access
  localparam logic [7:0] MUX_BASE_CLKS    = 8'h03;
  localparam logic [7:0] SEP_BASE_CLKS    = 8'h02;
  localparam logic [7:0] PERIPH_BASE_CLKS = 8'h03;

  typedef enum logic [1:0] {
    AREA_INT    = 2'b00,
    AREA_EXT    = 2'b01,
    AREA_PERIPH = 2'b10
  } ebswc_area_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } ebswc_size_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_ADDR   = 3'b010,
    ST_HOLD   = 3'b011,
    ST_SECOND = 3'b100,
    ST_WAIT   = 3'b101,
    ST_THIRD  = 3'b110
  } ebswc_state_t;

  typedef struct packed {
    logic [REQ_ADDR_W-1:0] addr;
    ebswc_size_t           size;
    logic                  write;
    logic [31:0]           wdata;
    ebswc_area_t           area;
  } ebswc_req_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] dout;
    logic        oe;
    logic        astb;
    logic        rd_n;
    logic        wrLo_n;
    logic        wrHi_n;
  } ebswc_pins_t;

endpackage : ebswc_pkg

// [verilog/ebswc_sync.sv]
`timescale 1ns/1ps
module ebswc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : ebswc_sync

// [verilog/ebswc_split.sv]
`timescale 1ns/1ps
module ebswc_split (
  // Sub-access position
  input  wire logic       odd,
  input  wire logic [2:0] remain,
  input  wire logic       wide,
  // Lane plan
  output logic      [1:0] count,
  output logic            loLane,
  output logic            hiLane
);
  always_comb begin
    if (!wide) begin
      count  = 2'd1;
      loLane = 1'b1;
      hiLane = 1'b0;
    end else if (odd) begin
      count  = 2'd1;
      loLane = 1'b0;
      hiLane = 1'b1;
    end else if (remain >= 3'd2) begin
      count  = 2'd2;
      loLane = 1'b1;
      hiLane = 1'b1;
    end else begin
      count  = 2'd1;
      loLane = 1'b1;
      hiLane = 1'b0;
    end
  end
endmodule : ebswc_split

// [verilog/ebswc_top.sv]
// Operation
// RL1: External access lasts 3+n+i clocks multiplexed, 2+n+i separate.
// RL2: Peripheral area access lasts 3 clocks plus peripheral wait setting.
// RL3: Per-block width bit: 0 selects 8-bit bus, 1 selects 16-bit.
// RL4: On 16-bit blocks even bytes use lines 7..0, odd bytes 15..8.
// RL5: Width register resets to 5555H; software keeps fixed bits as required.
// RL6: Separate low and high write strobes; single 16-bit read, unused byte dropped.
// RL7: Peripheral area is always a 16-bit bus.
// RL8: Little-endian order, least significant part transferred first.
// RL9: Any byte address accepted; misaligned data split into extra accesses.
// RL10: 16-bit halfword: even one access; odd upper lane then lower lane.
// RL11: 8-bit block: byte one access, halfword two consecutive byte accesses.
// RL12: 16-bit word: even two accesses; odd three, upper, both, lower.
// RL13: 8-bit block word uses four consecutive byte accesses.
// RL14: Zero to seven programmable waits per block; register resets 7777H.
// RL15: Internal memories get no waits; peripheral area only its own waits.
// RL16: Asserted wait pin stretches the cycle for as long as it is held.
// RL17: Wait pin sampled at falling edge multiplexed, rising edge separate.
// RL18: Wait pin honoured only while its pin-mode bit is one.
// RL19: A wait is inserted when programmed count or wait pin asks.
// RL20: Setup wait adds one clock before address, hold wait one after.
// RL21: Separate-bus select bit, zero multiplexed, one separate, resets zero.
// RL22: Split reads assembled; completion reported after the last sub-access.
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module ebswc_top
  import ebswc_pkg::*;
#(
  parameter int PIN_ADDR_W = 22
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite register slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Internal requester
  input  wire logic        reqValid,
  input  wire ebswc_req_t  reqIn,
  output logic             reqReady,
  output logic             rspValid,
  output logic      [31:0] rspRdata,
  // External bus pins
  output logic             busClockOutput,
  output ebswc_pins_t      pins,
  input  wire logic [15:0] dataIn,
  input  wire logic        waitIn_n
);
  if (PIN_ADDR_W != 22) begin : g_chk
    $error("ebswc_top: PIN_ADDR_W must be 22");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0]       widthCfg;
  logic [15:0]       waitCfg;
  logic [15:0]       addrWaitCfg;
  logic [WAIT_W-1:0] periphWaitCfg;
  logic              separateBusSelect;
  logic              waitPinModeBit;
  logic              wrPend;
  logic [7:0]        wrOfs;
  logic [31:0]       statusWord;
  logic [31:0]       next_hrdata;
  logic              addrPhase;
  ebswc_state_t      state;
  logic [2:0]        byteDone;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];
  assign statusWord = {24'h0, 1'b0, byteDone, 1'b0, state};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrOfs  <= 8'h00;
    end else if (hready) begin
      wrPend <= addrPhase && hwrite;
      wrOfs  <= haddr[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      widthCfg          <= RST_WIDTH; // RL5
      waitCfg           <= RST_WAIT; // RL14
      addrWaitCfg       <= RST_AWAIT;
      periphWaitCfg     <= RST_PWAIT;
      separateBusSelect <= 1'b0; // RL21
      waitPinModeBit    <= 1'b0;
    end else if (wrPend) begin
      case (wrOfs)
        OFS_WIDTH: widthCfg          <= hwdata[15:0]; // RL3
        OFS_WAIT:  waitCfg           <= hwdata[15:0];
        OFS_AWAIT: addrWaitCfg       <= hwdata[15:0];
        OFS_PWAIT: periphWaitCfg     <= hwdata[WAIT_W-1:0];
        OFS_MODE:  separateBusSelect <= hwdata[0];
        OFS_PIN:   waitPinModeBit    <= hwdata[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (haddr[7:0])
      OFS_WIDTH:  next_hrdata = {16'h0, widthCfg};
      OFS_WAIT:   next_hrdata = {16'h0, waitCfg};
      OFS_AWAIT:  next_hrdata = {16'h0, addrWaitCfg};
      OFS_PWAIT:  next_hrdata = {29'h0, periphWaitCfg};
      OFS_MODE:   next_hrdata = {31'h0, separateBusSelect};
      OFS_PIN:    next_hrdata = {31'h0, waitPinModeBit};
      OFS_STATUS: next_hrdata = statusWord;
      default:    next_hrdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hrdata <= 32'h0;
    else if (addrPhase && !hwrite) hrdata <= next_hrdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus clock divider and pin synchronisers
  logic        busClkHigh;
  logic        stateAdvance;
  logic        waitSync_n;
  logic [15:0] dataSync;

  // Free-running: each bus clock is one high and one low system clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busClkHigh <= 1'b1;
    else busClkHigh <= !busClkHigh;
  end
  assign stateAdvance   = !busClkHigh;
  assign busClockOutput = busClkHigh;

  ebswc_sync #(.W(1)) u_waitSync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (waitIn_n),
    .q     (waitSync_n)
  );

  ebswc_sync #(.W(16)) u_dataSync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (dataIn),
    .q     (dataSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer planning
  ebswc_req_t        cur;
  ebswc_state_t      next_state;
  logic              isPeriph;
  logic              sepMode;
  logic              wide;
  logic              setupEn;
  logic              holdEn;
  logic [WAIT_W-1:0] waitLoad;
  logic [WAIT_W-1:0] waitLeft;
  logic              extWaitSamp;
  logic [1:0]        reqBlk;
  logic [2:0]        totalBytes;
  logic [2:0]        nextDone;
  logic [23:0]       curAddr;
  logic [1:0]        subCount;
  logic              loLane;
  logic              hiLane;
  logic              busy;
  logic              ext;
  logic              accept;
  logic              extWaitLive;
  logic              needWait;
  logic              more;
  logic              subEnd;
  logic              subStart;
  logic [WAIT_W-1:0] loadVal;

  always_comb begin
    if (reqIn.addr[BLK3_BIT]) reqBlk = 2'd3;
    else if (reqIn.addr[BLK2_BIT]) reqBlk = 2'd2;
    else if (reqIn.addr[BLK1_BIT]) reqBlk = 2'd1;
    else reqBlk = 2'd0;
  end

  assign busy       = state != ST_IDLE;
  assign ext        = busy && !isPeriph;
  assign reqReady   = !busy && (stateAdvance || reqIn.area == AREA_INT);
  assign accept     = reqValid && reqReady;
  assign totalBytes = (cur.size == SZ_WORD) ? 3'd4 : (cur.size == SZ_HALF) ? 3'd2 : 3'd1;
  assign curAddr    = cur.addr + {21'h0, byteDone}; // RL9
  assign nextDone   = byteDone + {1'b0, subCount};
  assign more       = nextDone < totalBytes;
  // Pin waits are ignored for the peripheral area
  assign extWaitLive = waitPinModeBit && !waitSync_n && !isPeriph; // RL15 RL18
  assign needWait    = (waitLeft != '0) || (sepMode ? extWaitLive : extWaitSamp); // RL19
  assign subEnd      = stateAdvance && (state == ST_THIRD || (state == ST_SECOND && sepMode));
  assign subStart    = (state == ST_IDLE || state == ST_SECOND || state == ST_THIRD)
                     && (next_state == ST_SETUP || next_state == ST_ADDR);

  ebswc_split u_split (
    .odd    (curAddr[0]),
    .remain (totalBytes - byteDone),
    .wide   (wide),
    .count  (subCount),
    .loLane (loLane),
    .hiLane (hiLane)
  ); // RL4 RL10 RL11 RL12 RL13

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept && reqIn.area != AREA_INT) begin
          next_state = (reqIn.area == AREA_EXT
                        && addrWaitCfg[AW_STRIDE*reqBlk+AW_SETUP_BIT]) ? ST_SETUP : ST_ADDR;
        end
      end
      ST_SETUP: if (stateAdvance) next_state = ST_ADDR; // RL20
      ST_ADDR, ST_HOLD: begin
        if (stateAdvance) begin
          if (state == ST_ADDR && holdEn) next_state = ST_HOLD; // RL20
          else if (sepMode && needWait) next_state = ST_WAIT;
          else next_state = ST_SECOND;
        end
      end
      ST_SECOND: begin
        if (stateAdvance) begin
          if (!sepMode) next_state = needWait ? ST_WAIT : ST_THIRD;
          else if (more) next_state = setupEn ? ST_SETUP : ST_ADDR;
          else next_state = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (stateAdvance && !needWait) next_state = sepMode ? ST_SECOND : ST_THIRD; // RL16
      end
      ST_THIRD: begin // RL1
        if (stateAdvance) begin
          if (more) next_state = setupEn ? ST_SETUP : ST_ADDR;
          else next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= ST_IDLE;
    else state <= next_state;
  end

  // Config other than waitPinModeBit captured once per request so a mid-transfer write cannot tear it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur      <= '0;
      isPeriph <= 1'b0;
      sepMode  <= 1'b0;
      wide     <= 1'b0;
      setupEn  <= 1'b0;
      holdEn   <= 1'b0;
      waitLoad <= '0;
    end else if (accept && reqIn.area != AREA_INT) begin
      cur      <= reqIn;
      isPeriph <= reqIn.area == AREA_PERIPH;
      sepMode  <= separateBusSelect && reqIn.area == AREA_EXT; // RL2
      wide     <= reqIn.area == AREA_PERIPH || widthCfg[WIDTH_STRIDE*reqBlk]; // RL3 RL7
      setupEn  <= reqIn.area == AREA_EXT && addrWaitCfg[AW_STRIDE*reqBlk+AW_SETUP_BIT];
      holdEn   <= reqIn.area == AREA_EXT && addrWaitCfg[AW_STRIDE*reqBlk+AW_HOLD_BIT];
      waitLoad <= loadVal;
    end
  end

  always_comb begin
    if (state != ST_IDLE) loadVal = waitLoad;
    else if (reqIn.area == AREA_PERIPH) loadVal = periphWaitCfg; // RL2
    else loadVal = waitCfg[WAIT_STRIDE*reqBlk +: WAIT_W]; // RL14
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) waitLeft <= '0;
    else if (subStart) waitLeft <= loadVal;
    else if (stateAdvance && next_state == ST_WAIT && waitLeft != '0) waitLeft <= waitLeft - 1'b1;
  end

  // Multiplexed mode looks at the pin at the falling edge inside the state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) extWaitSamp <= 1'b0;
    else if (subStart) extWaitSamp <= 1'b0;
    else if (busClkHigh && (state == ST_SECOND || state == ST_WAIT)) extWaitSamp <= extWaitLive; // RL17
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) byteDone <= 3'd0;
    else if (accept) byteDone <= 3'd0;
    else if (subEnd) byteDone <= nextDone; // RL8
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read assembly and completion
  logic [3:0][7:0] rbuf;
  logic [3:0][7:0] next_rbuf;
  logic [1:0]      bIdx;

  assign bIdx = byteDone[1:0];

  // The read strobe always fetches 16 bits; the unwanted lane is dropped
  always_comb begin
    next_rbuf = rbuf;
    if (!isPeriph && !cur.write) begin
      if (loLane) next_rbuf[bIdx] = dataSync[7:0]; // RL6
      else next_rbuf[bIdx] = dataSync[15:8];
      if (subCount == 2'd2) next_rbuf[bIdx + 2'd1] = dataSync[15:8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rbuf <= '0;
    else if (accept) rbuf <= '0;
    else if (subEnd) rbuf <= next_rbuf;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rspValid <= 1'b0;
      rspRdata <= 32'h0;
    end else begin
      rspValid <= (accept && reqIn.area == AREA_INT) || (subEnd && !more); // RL15 RL22
      if (subEnd && !more) rspRdata <= next_rbuf;
      else if (accept) rspRdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  ebswc_pins_t next_pins;
  logic        addrStates;
  logic        dataStates;
  logic        muxAddr;
  logic        strobeOn;
  logic [7:0]  wbLo;
  logic [7:0]  wbNext;

  assign addrStates = state == ST_SETUP || state == ST_ADDR || state == ST_HOLD;
  assign dataStates = state == ST_SECOND || state == ST_WAIT || state == ST_THIRD;
  assign muxAddr    = ext && !sepMode && addrStates;
  assign strobeOn   = ext && (state == ST_SECOND || state == ST_WAIT);
  assign wbLo       = cur.wdata[{bIdx, 3'b000} +: 8];
  assign wbNext     = cur.wdata[{bIdx + 2'd1, 3'b000} +: 8];

  always_comb begin
    next_pins.addr   = curAddr[21:0];
    next_pins.astb   = ext && !sepMode && state == ST_ADDR;
    next_pins.oe     = muxAddr || (ext && cur.write && dataStates);
    next_pins.rd_n   = !(strobeOn && !cur.write);
    next_pins.wrLo_n = !(strobeOn && cur.write && loLane); // RL6
    next_pins.wrHi_n = !(strobeOn && cur.write && hiLane);
    if (muxAddr) next_pins.dout = curAddr[15:0];
    else next_pins.dout = {(subCount == 2'd2) ? wbNext : wbLo, wbLo}; // RL4
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pins <= '{addr: '0, dout: '0, oe: 1'b0, astb: 1'b0,
                          rd_n: 1'b1, wrLo_n: 1'b1, wrHi_n: 1'b1};
    else pins <= next_pins;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] subClks;
  logic [7:0] waitsDone;
  logic [7:0] expClks;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      subClks   <= 8'h0;
      waitsDone <= 8'h0;
    end else if (subStart) begin
      subClks   <= 8'h0;
      waitsDone <= 8'h0;
    end else if (stateAdvance && busy) begin
      subClks <= subClks + 8'h1;
      if (state == ST_WAIT) waitsDone <= waitsDone + 8'h1;
    end
  end

  assign expClks = (isPeriph ? PERIPH_BASE_CLKS : sepMode ? SEP_BASE_CLKS : MUX_BASE_CLKS)
                 + waitsDone + {7'h0, setupEn} + {7'h0, holdEn};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_access_clocks: assert property (subEnd |-> subClks + 8'h1 == expClks) // RL1 RL2 RL20
    else $error("access length wrong");
  a_wait_floor: assert property (subEnd |-> waitsDone >= {5'h0, waitLoad}) // RL14 RL19
    else $error("fewer waits than programmed");
  a_pin_wait_holds: assert property (stateAdvance && sepMode && state == ST_WAIT // RL16
    && extWaitLive |=> state == ST_WAIT) else $error("wait pin not honoured");
  a_internal_nowait: assert property (accept && reqIn.area == AREA_INT |=> rspValid) // RL15
    else $error("internal access delayed");
  a_reset_values: assert property ($rose(rst_n) |-> widthCfg == RST_WIDTH // RL5 RL14 RL21
    && waitCfg == RST_WAIT && !separateBusSelect) else $error("reset value wrong");
  a_narrow_bytes: assert property (ext && !wide |-> subCount == 2'd1 && loLane // RL11 RL13
    && !hiLane) else $error("narrow block lane wrong");
  a_odd_upper: assert property (busy && wide && curAddr[0] |-> hiLane && !loLane) // RL10 RL12
    else $error("odd byte not on upper lane");
  a_strobe_data: assert property (!pins.wrLo_n || !pins.wrHi_n |-> pins.oe && pins.rd_n) // RL6
    else $error("write strobe without data");
  a_byte_order: assert property (busy && $past(busy) && byteDone != $past(byteDone) // RL8
    |-> byteDone > $past(byteDone)) else $error("bytes out of order");
  a_last_done: assert property (rspValid && $past(busy) |-> $past(nextDone) == // RL22
    $past(totalBytes)) else $error("completion before last part");
endmodule : ebswc_top

// [test/ebswc_mem_model.sv]
`timescale 1ns/1ps
module ebswc_mem_model
  import ebswc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bus pins
  input  wire ebswc_pins_t pins,
  output logic      [15:0] dataIn,
  output logic             waitIn_n,
  // Bench controls
  input  wire logic        narrow,
  input  wire logic [3:0]  stallLen
);
  logic [7:0]  mem [256];
  logic [15:0] lastD;
  logic [1:0]  hold;
  logic [3:0]  cnt;
  wire         act    = !(pins.rd_n && pins.wrLo_n && pins.wrHi_n);
  wire  [7:0]  ae     = {pins.addr[7:1], 1'b0};
  wire  [15:0] rdWord = narrow ? {~mem[pins.addr[7:0]], mem[pins.addr[7:0]]}
                               : {mem[ae | 8'h01], mem[ae]};

  // Asynchronous memory: data follows the read strobe with no clock of delay
  assign dataIn   = pins.rd_n ? lastD : rdWord;
  assign waitIn_n = (cnt == 4'h0);

  // Wait held from idle so the early sample sees it; freed stallLen clocks into the strobe
  // Released lines hold for three clocks, then toggle so a later sample never looks valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastD <= 16'hA5C3;
      hold  <= 2'h0;
      cnt   <= 4'h0;
    end else begin
      if (!act) cnt <= stallLen;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      if (!pins.rd_n) begin
        lastD <= rdWord;
        hold  <= 2'h3;
      end else if (hold != 2'h0) hold <= hold - 2'h1;
      else lastD <= ~lastD;
    end
  end

  always @(posedge clk) begin
    if (!pins.wrLo_n) mem[narrow ? pins.addr[7:0] : ae] <= pins.dout[7:0];
    if (!pins.wrHi_n && !narrow) mem[ae | 8'h01] <= pins.dout[15:8];
  end
endmodule : ebswc_mem_model

// [test/ebswc_top_tb_top.sv]
`timescale 1ns/1ps
module ebswc_top_tb_top;
  import ebswc_pkg::*;
  typedef struct packed {
    logic        narrow;
    logic [7:0]  a;
    ebswc_size_t sz;
    logic [2:0]  n;
    logic [2:0]  subs;
  } ebswc_row_t;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, reqValid, reqReady, rspValid;
  logic        busClockOutput, waitIn_n, narrow, act, prev;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  stallLen;
  logic [7:0]  firstA;
  logic [15:0] dataIn;
  logic [31:0] haddr, hwdata, hrdata, rspRdata, rdata, q, w, mask;
  ebswc_req_t  reqIn;
  ebswc_pins_t pins;
  ebswc_row_t  r;
  int          badCount, comparisons, cycles, lat, subs, lowc, base;
  ebswc_row_t  rows [9] = '{
    '{1'b0, 8'h10, SZ_BYTE, 3'h0, 3'h1}, '{1'b0, 8'h11, SZ_BYTE, 3'h1, 3'h1},
    '{1'b0, 8'h20, SZ_HALF, 3'h0, 3'h1}, '{1'b0, 8'h23, SZ_HALF, 3'h2, 3'h2},
    '{1'b0, 8'h30, SZ_WORD, 3'h0, 3'h2}, '{1'b0, 8'h41, SZ_WORD, 3'h7, 3'h3},
    '{1'b1, 8'h51, SZ_HALF, 3'h0, 3'h2}, '{1'b1, 8'h62, SZ_WORD, 3'h3, 3'h4},
    '{1'b1, 8'h70, SZ_BYTE, 3'h1, 3'h1}};
  logic [7:0]  offs [7] = '{OFS_WIDTH, OFS_WAIT, OFS_AWAIT, OFS_PWAIT, OFS_MODE, OFS_PIN, 8'h1C};
  logic [31:0] rstv [7] = '{32'h5555, 32'h7777, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

  ebswc_top #(.PIN_ADDR_W(22)) u_ebswc_top (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .reqValid, .reqIn,
    .reqReady, .rspValid, .rspRdata, .busClockOutput, .pins, .dataIn, .waitIn_n);
  ebswc_mem_model u_ebswc_mem_model (.clk, .rst_n, .pins, .dataIn, .waitIn_n, .narrow,
    .stallLen);

  ////////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  // Whole run is under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  // Accept at the edge after reqReady is seen, then watch strobes to completion
  task automatic do_req(input ebswc_area_t ar, input logic [7:0] a, input ebswc_size_t sz,
                        input logic wr, input logic [31:0] d);
    reqIn    <= '{addr: {16'h0000, a}, size: sz, write: wr, wdata: d, area: ar};
    reqValid <= 1'b1;
    do @(negedge clk); while (reqReady !== 1'b1);
    @(posedge clk);
    reqValid <= 1'b0;
    lat  = 0;
    subs = 0;
    lowc = 0;
    prev = 1'b0;
    do begin
      @(negedge clk);
      lat++;
      act = !(pins.rd_n && pins.wrLo_n && pins.wrHi_n);
      if (act === 1'b1) lowc++;
      if (act === 1'b1 && !prev) begin
        if (subs == 0) firstA = pins.addr[7:0];
        subs++;
      end
      prev = act;
    end while (rspValid !== 1'b1 && lat < 600);
    if (rspValid !== 1'b1) badCount++;
    rdata = rspRdata;
    @(posedge clk);
  endtask : do_req

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rst_n, hsel, hwrite, reqValid, narrow} = '0;
    {htrans, hsize, stallLen, haddr, hwdata, reqIn} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    ahb(1'b1, OFS_AWAIT, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      narrow <= r.narrow;
      ahb(1'b1, OFS_WIDTH, r.narrow ? 32'h5554 : 32'h5555);
      ahb(1'b1, OFS_WAIT, {16'h0000, 12'h777, 1'b0, r.n});
      w    = 32'h8C4D1E2F + i;
      mask = (r.sz == SZ_BYTE) ? 32'hFF : (r.sz == SZ_HALF) ? 32'hFFFF : 32'hFFFFFFFF;
      for (int k = 0; k < 2; k++) begin
        do_req(AREA_EXT, r.a, r.sz, k == 0, w);
        check(subs, r.subs, "sub-access count");
        check(lowc, r.subs * 2 * (1 + r.n), "strobe clocks");
        check(firstA, r.a, "first address");
        if (k == 1) check(rdata, w & mask, "read data");
      end
      for (int k = 0; k < (1 << r.sz); k++)
        check(u_ebswc_mem_model.mem[8'(r.a + k)], w[8*k +: 8], "lane byte");
    end
    $display("test rows done");

    narrow <= 1'b0;
    ahb(1'b1, OFS_WIDTH, 32'h5555);
    ahb(1'b1, OFS_WAIT, 32'h0);
    do_req(AREA_EXT, 8'h80, SZ_WORD, 1'b1, w);
    base = lat;
    ahb(1'b1, OFS_MODE, 32'h1);
    do_req(AREA_EXT, 8'h80, SZ_WORD, 1'b1, w);
    check(base - lat, 4, "separate mode clocks");
    ahb(1'b1, OFS_MODE, 32'h0);
    ahb(1'b1, OFS_AWAIT, 32'h3);
    do_req(AREA_EXT, 8'h80, SZ_WORD, 1'b1, w);
    check(lat - base, 8, "address waits");
    ahb(1'b1, OFS_AWAIT, 32'h0);
    $display("test timing done");

    stallLen <= 4'h8;
    do_req(AREA_EXT, 8'h90, SZ_BYTE, 1'b1, w);
    check(lowc, 2, "wait pin ignored");
    ahb(1'b1, OFS_PIN, 32'h1);
    do_req(AREA_EXT, 8'h90, SZ_BYTE, 1'b1, w);
    check(lowc >= 8 && lowc <= 16, 1, "wait pin stretch");
    ahb(1'b1, OFS_MODE, 32'h1);
    do_req(AREA_EXT, 8'h90, SZ_BYTE, 1'b1, w);
    check(lowc >= 8 && lowc <= 16, 1, "separate wait pin");
    ahb(1'b1, OFS_MODE, 32'h0);
    stallLen <= 4'h0;
    $display("test wait pin done");

    do_req(AREA_INT, 8'h00, SZ_WORD, 1'b0, w);
    check(lat, 1, "internal latency");
    check(subs, 0, "internal pins");
    do_req(AREA_PERIPH, 8'h00, SZ_WORD, 1'b0, w);
    base = lat;
    check(subs, 0, "peripheral pins");
    check(rdata, 32'h0, "peripheral data");
    ahb(1'b1, OFS_PWAIT, 32'h2);
    do_req(AREA_PERIPH, 8'h00, SZ_WORD, 1'b0, w);
    check(lat > base, 1, "peripheral waits");
    $display("test areas done");

    // Reset in mid-run proves the values below, bar OFS_WIDTH and OFS_MODE, come from reset, not leftovers
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b1, 8'h1C, 32'hFFFFFFFF);
    foreach (offs[i]) begin
      ahb(1'b0, offs[i], 32'h0);
      check(q, rstv[i], "reset value");
    end
    $display("test reset done");
    finish_test();
  end
endmodule : ebswc_top_tb_top
